/* File: dv/pga_pin_model.sv */
// far-side logic model: resolves each pin from the port and the outside
// assumes oe high means the port drives the pin; no pull-ups on this port
`timescale 1ns/10ps

module pga_pin_model
(
   input wire logic [pga_pkg::PORT_W-1:0] pin_val_i,
   input wire logic [pga_pkg::PORT_W-1:0] pin_oe_i,
   input wire logic [pga_pkg::PORT_W-1:0] ext_i,
   output logic [pga_pkg::PORT_W-1:0] lvl_o
);
   // released pins show the outside level, never the port's stale value
   assign lvl_o = (pin_oe_i & pin_val_i) | (~pin_oe_i & ext_i);
endmodule

/* File: dv/test_pga_port.sv */
// self-checking bench of the eight-pin address/gpio port
// assumes the pin model resolves pins; modes are strapped during reset
`timescale 1ns/10ps

module test_pga_port;
   // ----------------------------------------------------------------
   // stimulus and wiring
   // ----------------------------------------------------------------
   logic clk_i = 0;
   logic rst_i = 1;
   logic [2:0] mode = 3'h6;
   logic hw_sb = 0;
   logic sw_sb = 0;
   logic [19:0] adr = 20'h00000;
   logic [31:0] wdat = 32'h00000000;
   logic [3:0] sel = 4'h0;
   logic we = 0;
   logic cyc = 0;
   logic stb = 0;
   pga_pkg::pga_addr_type asrc = '0;
   logic [7:0] ext = 8'hC3;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic ack;
   logic [7:0] pin_lvl;
   logic [7:0] pin_o;
   logic [7:0] pin_oe;
   int fail_count = 0;
   int checks = 0;

   pga_port uut (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .hw_standby_i(hw_sb),
      .sw_standby_i(sw_sb), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .addr_i(asrc), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe));
   pga_pin_model far (.pin_val_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext), .lvl_o(pin_lvl));

   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // classic cycle: hold until ack is sampled, release at that edge
   task automatic wb(input logic [19:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      rdat = dat_o;
      if (n >= 50)
         chk32(32'hDEAD0000, 32'h00000000);
      cyc <= 0;
      stb <= 0;
      we <= 0;
      sel <= 4'h0;
   endtask

   // pins settle one cycle after state; three edges leave margin
   task automatic pins(input logic [7:0] m, input logic [7:0] oe, input logic [7:0] o);
      repeat (3) @(posedge clk_i);
      #1;
      chk8(pin_oe, oe);
      chk8(pin_o & m, o);
   endtask

   task automatic restart(input logic [2:0] m);
      @(posedge clk_i);
      mode <= m;
      rst_i <= 1;
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_single();
      pins(8'hFF, 8'h00, 8'h00);
      wb(20'hFFFD0, 0, 0);
      chk32(rdat, 32'h000000C3);
      wb(20'hEE000, 0, 0);
      chk32(rdat, 32'h000000FF);
      wb(20'h00010, 0, 0);
      chk32(rdat, 32'h00000000);
      wb(20'hEE000, 1, 32'h0000000F);
      wb(20'hFFFD0, 1, 32'h000000A5);
      pins(8'h0F, 8'h0F, 8'h05);
      wb(20'hFFFD0, 0, 0);
      chk32(rdat, 32'h000000C5);
   endtask

   task automatic t_standby();
      @(posedge clk_i);
      sw_sb <= 1;
      wb(20'hEE000, 1, 32'h000000FF);
      wb(20'hFFFD0, 1, 32'h00000000);
      @(posedge clk_i);
      sw_sb <= 0;
      pins(8'h0F, 8'h0F, 8'h05);
      wb(20'hFFFD0, 0, 0);
      chk32(rdat, 32'h000000C5);
      @(posedge clk_i);
      hw_sb <= 1;
      pins(8'h00, 8'h00, 8'h00);
      @(posedge clk_i);
      hw_sb <= 0;
      pins(8'h00, 8'h00, 8'h00);
      wb(20'hEE000, 1, 32'h000000FF);
      wb(20'hFFFD0, 0, 0);
      chk32(rdat, 32'h00000000);
   endtask

   task automatic t_rom();
      restart(3'h5);
      pins(8'h00, 8'h00, 8'h00);
      asrc.addr <= 8'h3C;
      wb(20'hEE000, 1, 32'h000000F0);
      pins(8'hF0, 8'hF0, 8'h30);
      @(posedge clk_i);
      asrc <= '{cycle: 1, col_phase: 0, row: 8'h9A, col: 8'h67, addr: 8'h3C};
      pins(8'hF0, 8'hF0, 8'h90);
      @(posedge clk_i);
      asrc.col_phase <= 1;
      pins(8'hF0, 8'hF0, 8'h60);
   endtask

   task automatic t_bus();
      restart(3'h2);
      asrc <= '{cycle: 0, col_phase: 0, row: 8'h9A, col: 8'h67, addr: 8'h5A};
      pins(8'hFF, 8'hFF, 8'h5A);
      wb(20'hEE000, 1, 32'h00000000);
      pins(8'hFF, 8'hFF, 8'h5A);
      wb(20'hEE000, 0, 0);
      chk32(rdat, 32'h000000FF);
      @(posedge clk_i);
      asrc.cycle <= 1;
      pins(8'hFF, 8'hFF, 8'h9A);
   endtask

   task automatic t_single_b();
      restart(3'h7);
      pins(8'hFF, 8'h00, 8'h00);
      wb(20'hFFFD0, 1, 32'h0000003C);
      wb(20'hEE000, 1, 32'h000000F0);
      pins(8'hF0, 8'hF0, 8'h30);
      wb(20'hFFFD0, 0, 0);
      chk32(rdat, 32'h00000033);
   endtask

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      t_single();
      t_standby();
      t_rom();
      t_bus();
      t_single_b();
      finish_test();
   end

   // whole run is about 130 cycles; this allows 5000 cycles, near forty times that
   initial
   begin
      #20000;
      fail_count++;
      finish_test();
   end
endmodule

/* File: hdl/pga_pkg.sv */
// constants, types and state layout of the eight-pin address/gpio port
// assumes a 20-bit byte-addressed classic wishbone bus with 32-bit data

package pga_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADR_W = 20;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;
   localparam int PORT_W = 8;
   localparam int MODE_W = 3;
   localparam int WORD_LSB = 2;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [ADR_W-1:0] PORT_DIRECTION_OFS = 20'hEE000;
   localparam logic [ADR_W-1:0] PORT_OUTPUT_DATA_OFS = 20'hFFFD0;

   // ----------------------------------------------------------------
   // reset and fixed values
   // ----------------------------------------------------------------
   localparam logic [PORT_W-1:0] DIR_RST_ADDR_BUS = 8'hFF;
   localparam logic [PORT_W-1:0] DIR_RST_GPIO = 8'h00;
   localparam logic [PORT_W-1:0] DIR_READ_VALUE = 8'hFF;
   localparam logic [PORT_W-1:0] DATA_RST = 8'h00;
   localparam logic [PORT_W-1:0] ALL_DRIVE = 8'hFF;
   localparam logic [PORT_W-1:0] NONE_DRIVE = 8'h00;
   localparam logic [DAT_W-1:0] READ_ZERO = 32'h0000_0000;
   localparam logic [DAT_W-PORT_W-1:0] UPPER_ZERO = 24'h00_0000;

   // ----------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------
   localparam logic [MODE_W-1:0] MODE_ROM_EXP = 3'h5;
   localparam logic [MODE_W-1:0] MODE_SINGLE_A = 3'h6;
   localparam logic [MODE_W-1:0] MODE_SINGLE_B = 3'h7;

   typedef enum logic [1:0] {
      FN_ADDR_BUS,
      FN_ROM_EXP,
      FN_SINGLE
   } pga_func_type;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cycle;
      logic col_phase;
      logic [PORT_W-1:0] row;
      logic [PORT_W-1:0] col;
      logic [PORT_W-1:0] addr;
   } pga_addr_type;

   typedef struct packed {
      logic [MODE_W-1:0] mode;
      logic [PORT_W-1:0] dir;
      logic [PORT_W-1:0] data;
      logic [PORT_W-1:0] sync1;
      logic [PORT_W-1:0] sync2;
      logic ack;
      logic [DAT_W-1:0] rdata;
      logic [PORT_W-1:0] pin_out;
      logic [PORT_W-1:0] pin_oe;
   } pga_state_type;

endpackage

/* File: hdl/pga_port.sv */
// eight-pin port: low address byte or general-purpose i/o, per mode
// assumes mode_i is a strap stable around reset; pins resolved outside
//
// Summary of operation
// - modes 1 to 4 drive all pins with address bits 7..0.
// - mode 5: direction 1 gives address output, direction 0 gives input.
// - mode 5: after reset every pin is an input.
// - modes 6 and 7: direction 1 gives data output, 0 gives input.
// - modes 1 to 4: direction reads all ones, writes ignored.
// - modes 5 to 7: direction is write only, reads all ones.
// - reset or hardware standby: direction FF in modes 1-4, 00 otherwise.
// - software standby keeps direction, so outputs keep driving.
// - general output pins carry the output data register bits.
// - data read: pin level where direction 0, stored bit where 1.
// - data register clears on reset or hardware standby, kept in standby.
// - dram cycles put row then column address on the pins.
// - both registers eight bits, bit n belongs to pin n.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps

module pga_port
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [pga_pkg::MODE_W-1:0] mode_i,
   input wire logic hw_standby_i,
   input wire logic sw_standby_i,
   input wire logic [pga_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [pga_pkg::DAT_W-1:0] wb_dat_i,
   input wire logic [pga_pkg::SEL_W-1:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [pga_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire pga_pkg::pga_addr_type addr_i,
   input wire logic [pga_pkg::PORT_W-1:0] pin_i,
   output logic [pga_pkg::PORT_W-1:0] pin_o,
   output logic [pga_pkg::PORT_W-1:0] pin_oe_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pga_pkg::pga_state_type s_q;
   pga_pkg::pga_state_type s_d;
   pga_pkg::pga_func_type func;
   pga_pkg::pga_func_type rst_func;
   logic [pga_pkg::PORT_W-1:0] addr_mux;
   logic [pga_pkg::PORT_W-1:0] data_view;
   logic req;
   logic hit_dir;
   logic hit_data;
   logic wr_take;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic pga_pkg::pga_func_type func_of(input logic [pga_pkg::MODE_W-1:0] m);
      pga_pkg::pga_func_type f;
      f = pga_pkg::FN_ADDR_BUS;
      if (m == pga_pkg::MODE_ROM_EXP)
      begin
         f = pga_pkg::FN_ROM_EXP;
      end
      else if ((m == pga_pkg::MODE_SINGLE_A) || (m == pga_pkg::MODE_SINGLE_B))
      begin
         f = pga_pkg::FN_SINGLE;
      end
      return f;
   endfunction

   always_comb
   begin
      func = func_of(s_q.mode);
      rst_func = func_of(mode_i);
      req = wb_cyc_i & wb_stb_i;
      // word compare only: address bits 1..0 make no difference; writes still need byte lane 0
      hit_dir = (wb_adr_i[pga_pkg::ADR_W-1:pga_pkg::WORD_LSB] ==
                 pga_pkg::PORT_DIRECTION_OFS[pga_pkg::ADR_W-1:pga_pkg::WORD_LSB]);
      hit_data = (wb_adr_i[pga_pkg::ADR_W-1:pga_pkg::WORD_LSB] ==
                  pga_pkg::PORT_OUTPUT_DATA_OFS[pga_pkg::ADR_W-1:pga_pkg::WORD_LSB]);
      // write lands on the edge where ack is seen high; cpu halted in standby
      wr_take = req & s_q.ack & wb_we_i & wb_sel_i[0] & ~sw_standby_i;
      // dram cycles swap row and column on the same pins
      if (addr_i.cycle)
      begin
         addr_mux = addr_i.col_phase ? addr_i.col : addr_i.row;
      end
      else
      begin
         addr_mux = addr_i.addr;
      end
      data_view = (s_q.dir & s_q.data) | (~s_q.dir & s_q.sync2);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      // synchroniser: first stage feeds only the second
      s_d.sync1 = pin_i;
      s_d.sync2 = s_q.sync1;

      // bus answer: one wait state, ack dropped after one cycle
      s_d.ack = req & ~s_q.ack;
      if (req & ~s_q.ack & ~wb_we_i)
      begin
         if (hit_dir)
         begin
            s_d.rdata = {pga_pkg::UPPER_ZERO, pga_pkg::DIR_READ_VALUE};
         end
         else if (hit_data)
         begin
            s_d.rdata = {pga_pkg::UPPER_ZERO, data_view};
         end
         else
         begin
            s_d.rdata = pga_pkg::READ_ZERO;
         end
      end

      // register writes
      if (wr_take && hit_dir && (func != pga_pkg::FN_ADDR_BUS))
      begin
         s_d.dir = wb_dat_i[pga_pkg::PORT_W-1:0];
      end
      if (wr_take && hit_data)
      begin
         s_d.data = wb_dat_i[pga_pkg::PORT_W-1:0];
      end

      // pin drive per mode; software standby changes none of it
      case (func)
         pga_pkg::FN_ADDR_BUS:
         begin
            s_d.pin_out = addr_mux;
            s_d.pin_oe = pga_pkg::ALL_DRIVE;
         end
         pga_pkg::FN_ROM_EXP:
         begin
            s_d.pin_out = addr_mux;
            s_d.pin_oe = s_q.dir;
         end
         default:
         begin
            s_d.pin_out = s_q.data;
            s_d.pin_oe = s_q.dir;
         end
      endcase

      // reset and hardware standby: strap taken, registers initialised
      if (rst_i || hw_standby_i)
      begin
         s_d.mode = mode_i;
         s_d.data = pga_pkg::DATA_RST;
         s_d.ack = 1'b0;
         s_d.rdata = pga_pkg::READ_ZERO;
         s_d.pin_out = pga_pkg::DATA_RST;
         if (rst_func == pga_pkg::FN_ADDR_BUS)
         begin
            s_d.dir = pga_pkg::DIR_RST_ADDR_BUS;
         end
         else
         begin
            s_d.dir = pga_pkg::DIR_RST_GPIO;
         end
         // pins float in hardware standby; driven by mode after reset
         if (hw_standby_i || (rst_func != pga_pkg::FN_ADDR_BUS))
         begin
            s_d.pin_oe = pga_pkg::NONE_DRIVE;
         end
         else
         begin
            s_d.pin_oe = pga_pkg::ALL_DRIVE;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      s_q <= s_d;
   end

   assign wb_dat_o = s_q.rdata;
   assign wb_ack_o = s_q.ack;
   assign pin_o = s_q.pin_out;
   assign pin_oe_o = s_q.pin_oe;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking

   sequence rd_dir_seq;
      req && !wb_we_i && hit_dir && !s_q.ack;
   endsequence

   sequence rd_data_seq;
      req && !wb_we_i && hit_data && !s_q.ack;
   endsequence

   sequence quiet_seq;
      !rst_i && !hw_standby_i;
   endsequence

   a_addr_bus_drive: assert property (
      disable iff (rst_i)
      (quiet_seq and (func == pga_pkg::FN_ADDR_BUS)) |=> (pin_oe_o == pga_pkg::ALL_DRIVE)
         && (pin_o == $past(addr_mux)))
   else $error("address mode pins not driven with address");

   a_rom_exp_dir: assert property (
      disable iff (rst_i)
      (quiet_seq and (func == pga_pkg::FN_ROM_EXP)) |=> (pin_oe_o == $past(s_q.dir))
         && (pin_o == $past(addr_mux)))
   else $error("mode 5 pin drive does not follow direction");

   a_mode5_reset_input: assert property (
      (rst_i && !hw_standby_i && (mode_i == pga_pkg::MODE_ROM_EXP))
         ##1 quiet_seq |=> (pin_oe_o == pga_pkg::NONE_DRIVE))
   else $error("mode 5 pins not inputs after reset");

   a_single_out_data: assert property (
      disable iff (rst_i)
      (quiet_seq and (func == pga_pkg::FN_SINGLE)) |=> (pin_o == $past(s_q.data))
         && (pin_oe_o == $past(s_q.dir)))
   else $error("single chip pins do not carry data register");

   a_dir_locked_ones: assert property (
      disable iff (rst_i || hw_standby_i)
      (func == pga_pkg::FN_ADDR_BUS) |-> (s_q.dir == pga_pkg::DIR_RST_ADDR_BUS))
   else $error("direction changed in address bus mode");

   a_dir_read_ones: assert property (
      disable iff (rst_i || hw_standby_i)
      rd_dir_seq |=> wb_ack_o && (wb_dat_o == {pga_pkg::UPPER_ZERO, pga_pkg::DIR_READ_VALUE}))
   else $error("direction read did not return all ones");

   a_dir_reset_value: assert property (
      (rst_i && (func_of(mode_i) != pga_pkg::FN_ADDR_BUS))
         |=> (s_q.dir == pga_pkg::DIR_RST_GPIO) && (s_q.data == pga_pkg::DATA_RST))
   else $error("register reset value wrong for gpio modes");

   a_standby_holds: assert property (
      disable iff (rst_i || hw_standby_i)
      sw_standby_i[*2] |-> $stable(s_q.dir) && $stable(s_q.data))
   else $error("registers changed in software standby");

   a_data_read_mix: assert property (
      disable iff (rst_i || hw_standby_i)
      rd_data_seq |=> wb_ack_o && (wb_dat_o[pga_pkg::PORT_W-1:0] == $past(data_view)))
   else $error("data read mixes pins and register wrongly");

   a_ack_one_cycle: assert property (
      disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
   else $error("ack held longer than one cycle");

   a_sync_two_stage: assert property (
      disable iff (rst_i)
      1'b1 ##2 1'b1 |-> (s_q.sync2 == $past(pin_i, 2)))
   else $error("pin synchroniser depth wrong");

   // ----------------------------------------------------------------
   // bus write and refusal checks
   // ----------------------------------------------------------------
   sequence wr_ack_seq;
      req && wb_we_i && s_q.ack && wb_sel_i[0] && !sw_standby_i;
   endsequence

   sequence wr_held_seq;
      req && wb_we_i && s_q.ack && sw_standby_i;
   endsequence

   sequence rd_other_seq;
      req && !wb_we_i && !hit_dir && !hit_data && !s_q.ack;
   endsequence

   a_data_write_lands: assert property (
      disable iff (rst_i || hw_standby_i)
      (wr_ack_seq and hit_data) |=> (s_q.data == $past(wb_dat_i[pga_pkg::PORT_W-1:0])))
   else $error("data register write did not land");

   a_dir_write_lands: assert property (
      disable iff (rst_i || hw_standby_i)
      (wr_ack_seq and (hit_dir && (func != pga_pkg::FN_ADDR_BUS)))
         |=> (s_q.dir == $past(wb_dat_i[pga_pkg::PORT_W-1:0])))
   else $error("direction write did not land in gpio modes");

   a_standby_drops_write: assert property (
      disable iff (rst_i || hw_standby_i)
      wr_held_seq |=> $stable(s_q.dir) && $stable(s_q.data))
   else $error("write took effect in software standby");

   a_ack_after_req: assert property (
      disable iff (rst_i || hw_standby_i)
      (req && !s_q.ack) |=> wb_ack_o)
   else $error("request not acknowledged next cycle");

   a_unmapped_read_zero: assert property (
      disable iff (rst_i || hw_standby_i)
      rd_other_seq |=> wb_ack_o && (wb_dat_o == pga_pkg::READ_ZERO))
   else $error("unmapped read did not return zero");

   // ----------------------------------------------------------------
   // reset, standby and strap checks
   // ----------------------------------------------------------------
   a_hw_standby_float: assert property (
      hw_standby_i |=> (pin_oe_o == pga_pkg::NONE_DRIVE))
   else $error("pins driven in hardware standby");

   a_data_reset_value: assert property (
      (rst_i || hw_standby_i) |=> (s_q.data == pga_pkg::DATA_RST))
   else $error("data register not cleared by reset");

   a_dir_reset_bus: assert property (
      ((rst_i || hw_standby_i) && (func_of(mode_i) == pga_pkg::FN_ADDR_BUS))
         |=> (s_q.dir == pga_pkg::DIR_RST_ADDR_BUS))
   else $error("direction not all ones after reset in bus modes");

   a_reset_ack_low: assert property (
      rst_i |=> !wb_ack_o)
   else $error("ack high after a reset cycle");

   // strap is only taken while reset or hardware standby is high
   a_mode_held: assert property (
      disable iff (rst_i || hw_standby_i)
      quiet_seq |=> $stable(s_q.mode))
   else $error("mode changed outside reset");

   // ----------------------------------------------------------------
   // dram row and column checks
   // ----------------------------------------------------------------
   sequence dram_row_seq;
      !rst_i && !hw_standby_i && (func != pga_pkg::FN_SINGLE) && addr_i.cycle
         && !addr_i.col_phase;
   endsequence

   sequence dram_col_seq;
      !rst_i && !hw_standby_i && (func != pga_pkg::FN_SINGLE) && addr_i.cycle
         && addr_i.col_phase;
   endsequence

   a_dram_row_out: assert property (
      dram_row_seq |=> (pin_o == $past(addr_i.row)))
   else $error("dram row address not on pins");

   a_dram_col_out: assert property (
      dram_col_seq |=> (pin_o == $past(addr_i.col)))
   else $error("dram column address not on pins");

endmodule
